// File: src/async_serial_defines.vh
/*
 Constants of the asynchronous serial unit: oversampling, frame lengths,
 baud prescaler table, buffer size and state codes.
 Assumes a 125 MHz system clock and inclusion by bare name.
*/
`ifndef ASYNC_SERIAL_DEFINES_VH
`define ASYNC_SERIAL_DEFINES_VH

// Clock cycles per oversample tick at the fastest setting
`define RT_UNIT 16'h0004
// Oversample ticks per bit
`define RT_PER_BIT 5'h10
`define RT_FIRST 5'h01
// Start verification samples
`define RT_VERIFY_A 5'h03
`define RT_VERIFY_B 5'h05
`define RT_VERIFY_C 5'h07
// Majority vote samples within each bit
`define RT_VOTE_A 5'h08
`define RT_VOTE_B 5'h09
`define RT_VOTE_C 5'h0a
// Frame lengths in bits: start, data, stop
`define FRAME_LEN_8 4'ha
`define FRAME_LEN_9 4'hb
// Ticks of high line that make an idle string
`define IDLE_TICKS_8 8'ha0
`define IDLE_TICKS_9 8'hb0
// Prescaler factors chosen by the two high baud select bits
`define PRESCALE_0 5'h01
`define PRESCALE_1 5'h03
`define PRESCALE_2 5'h04
`define PRESCALE_3 5'h0d
// Transmit holding buffer
`define TX_FIFO_WIDTH 9
`define TX_FIFO_DEPTH 16
`define TX_FIFO_ADDR 4
// Receiver states
`define RX_IDLE 3'h0
`define RX_VERIFY 3'h1
`define RX_FRAME 3'h2
`define RX_AWAIT 3'h3
`define RX_NEED_HIGH 3'h4
// Transmitter states
`define TX_OFF 3'h0
`define TX_PREAMBLE 3'h1
`define TX_READY 3'h2
`define TX_DATA 3'h3
`define TX_BREAK 3'h4
`define TX_STOP_HIGH 3'h5

`endif

// File: src/sync_fifo.v
/*
 Synchronous FIFO with valid/ready handshakes on both sides.
 Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 16,
	parameter ADDR = 4
) (
	input wire clk,
	input wire rst,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [ADDR-1:0] wrPtr;
reg [ADDR-1:0] rdPtr;
reg [ADDR:0] count;
reg full;
reg empty;
wire push;
wire pop;

assign inReady = ~full;
assign outValid = ~empty;
assign outData = mem[rdPtr];
assign push = inValid & ~full;
assign pop = outReady & ~empty;

////////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
	if (push) begin
		mem[wrPtr] <= inData;
	end
end

always @(posedge clk) begin
	if (rst) begin
		wrPtr <= {ADDR{1'b0}};
		rdPtr <= {ADDR{1'b0}};
		count <= {(ADDR+1){1'b0}};
		full <= 1'b0;
		empty <= 1'b1;
	end else begin
		if (push) begin
			wrPtr <= wrPtr + 1'b1;
		end
		if (pop) begin
			rdPtr <= rdPtr + 1'b1;
		end
		if (push && !pop) begin
			count <= count + 1'b1;
			full <= (count == DEPTH - 1);
			empty <= 1'b0;
		end else if (pop && !push) begin
			count <= count - 1'b1;
			full <= 1'b0;
			empty <= (count == 1);
		end
	end
end

endmodule

`default_nettype wire

// File: src/async_serial_unit.v
/*
 Full-duplex asynchronous serial transceiver: baud generator, 16x
 oversampling receiver with voting and wake-up, transmitter with preamble,
 break and a 16-word holding FIFO behind the shared data port.
 Assumes the CPU side gives one-cycle read and write strobes and that the
 serial input is already synchronous to clk.
*/

// Overview of operation
// - Frame is one low start, eight or nine data bits, one high stop.
// - Transmitter and receiver independent but share format and bit rate.
// - Noise as short as one sixteenth bit time is flagged.
// - Software picks one of thirty-two bit rates for both directions.
// - Output pin driven whenever transmitter enabled, ignoring port direction.
// - High is one, low is zero; idle line rests high.
// - Every frame starts with a logic-zero start bit.
// - Data bits go least significant first.
// - Break is low for a whole multiple of the frame length; the code holds it low one bit short of each multiple.
// - Asleep in idle wake-up: no flags until ten or eleven ones.
// - Line sampled at sixteen times bit rate while awaiting start.
// - Three verification samples; two or more low accept the start.
// - One high verification sample sets noise yet accepts start.
// - Each start bit resynchronises receiver bit timing.
// - Bits sampled at ticks eight, nine, ten; majority wins.
// - Disagreeing samples on start, data or stop set noise.
// - Non-break framing error places an artificial start, never early; the code places it at the stop bit's last tick, one tick early.
// - Break framing error needs a real high bit before start.
// - Data port reads receive holding, writes transmit holding.
// - Holding word moves to shifter after current character, on bit clock.
// - Word-length bit: zero for eight data bits, one for nine.
// - Address wake-up: top data bit of the word wakes receiver.
// - Idle wake clears sleep after ten or eleven ones; no sleep when idle.
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_defines.vh"

module async_serial_unit (
	input wire clk,
	input wire rst,
	input wire dataWrite,
	input wire dataRead,
	input wire [7:0] writeData,
	input wire txBit8,
	output reg [7:0] readData,
	output reg rxBit8,
	output wire txReady,
	input wire [4:0] baudSelect,
	input wire wordLength9,
	input wire wakeByAddress,
	input wire txEnable,
	input wire rxEnable,
	input wire sendBreak,
	input wire rxSleepSet,
	output reg rx_sleep,
	output reg rx_full_flag,
	output reg noise_flag,
	output reg framing_flag,
	output reg txEmpty,
	output reg txComplete,
	input wire serial_in_pin,
	input wire port_dir_bit1,
	input wire portOutData,
	output reg serialOut,
	output reg serialOutEn_n
);

////////////////////////////////////////////////////////////////////////////
// Baud generator: one reload value feeds both directions
reg [4:0] prescale;
reg [15:0] rtReload;
reg [15:0] rtCount;
reg rtTick;
reg [3:0] txSub;
wire txTick;

always @* begin
	case (baudSelect[4:3])
	2'h0: prescale = `PRESCALE_0;
	2'h1: prescale = `PRESCALE_1;
	2'h2: prescale = `PRESCALE_2;
	2'h3: prescale = `PRESCALE_3;
	default: prescale = `PRESCALE_0;
	endcase
	rtReload = (({11'h000, prescale} << baudSelect[2:0]) * `RT_UNIT)
		- 16'h0001;
end

always @(posedge clk) begin
	if (rst) begin
		rtCount <= 16'h0000;
		rtTick <= 1'b0;
		txSub <= 4'h0;
	end else begin
		rtTick <= (rtCount == 16'h0000);
		rtCount <= (rtCount == 16'h0000) ? rtReload : rtCount - 16'h0001;
		if (rtTick) begin
			txSub <= txSub + 4'h1;
		end
	end
end

assign txTick = rtTick && (txSub == 4'hf);

////////////////////////////////////////////////////////////////////////////
// Receiver
reg [2:0] rxState;
reg [4:0] rtNum;
reg [3:0] bitIdx;
reg [1:0] highCount;
reg [1:0] votes;
reg [8:0] rxShift;
reg noisePend;
reg [7:0] highRun;
reg [8:0] rxData;
reg vote;
reg disagree;
reg [8:0] word;
wire [3:0] frameLen;
wire [3:0] stopIdx;
wire [7:0] idleTicks;
wire lineIdle;
wire [1:0] verifyHighs;

assign frameLen = wordLength9 ? `FRAME_LEN_9 : `FRAME_LEN_8;
assign stopIdx = frameLen - 4'h1;
assign idleTicks = wordLength9 ? `IDLE_TICKS_9 : `IDLE_TICKS_8;
assign lineIdle = (highRun >= idleTicks);
assign verifyHighs = highCount + {1'b0, serial_in_pin};

always @* begin
	vote = (votes[0] & votes[1]) | (votes[0] & serial_in_pin)
		| (votes[1] & serial_in_pin);
	disagree = (votes[0] != votes[1]) || (votes[1] != serial_in_pin);
	word = wordLength9 ? rxShift : {1'b0, rxShift[8:1]};
end

always @(posedge clk) begin
	if (rst) begin
		highRun <= 8'h00;
	end else if (rtTick) begin
		if (!serial_in_pin) begin
			highRun <= 8'h00;
		end else if (!lineIdle) begin
			highRun <= highRun + 8'h01;
		end
	end
end

always @(posedge clk) begin
	if (rst) begin
		rxState <= `RX_IDLE;
		rtNum <= `RT_FIRST;
		bitIdx <= 4'h0;
		highCount <= 2'h0;
		votes <= 2'h0;
		rxShift <= 9'h000;
		noisePend <= 1'b0;
		rxData <= 9'h000;
		rx_full_flag <= 1'b0;
		noise_flag <= 1'b0;
		framing_flag <= 1'b0;
		rx_sleep <= 1'b0;
	end else begin
		// Read clears flags; a frame ending the same cycle wins below
		if (dataRead) begin
			rx_full_flag <= 1'b0;
			noise_flag <= 1'b0;
			framing_flag <= 1'b0;
		end
		if (rxSleepSet && !lineIdle) begin
			rx_sleep <= 1'b1;
		end else if (rx_sleep && !wakeByAddress && lineIdle) begin
			rx_sleep <= 1'b0;
		end
		if (!rxEnable) begin
			rxState <= `RX_IDLE;
		end else if (rtTick) begin
			case (rxState)
			`RX_IDLE: begin
				if (!serial_in_pin) begin
					rxState <= `RX_VERIFY;
					rtNum <= `RT_FIRST + 5'h01;
					highCount <= 2'h0;
					noisePend <= 1'b0;
				end
			end
			`RX_VERIFY: begin
				rtNum <= rtNum + 5'h01;
				if (rtNum == `RT_VERIFY_A || rtNum == `RT_VERIFY_B) begin
					highCount <= verifyHighs;
				end
				if (rtNum == `RT_VERIFY_C) begin
					if (verifyHighs >= 2'h2) begin
						rxState <= `RX_IDLE;
					end else begin
						rxState <= `RX_FRAME;
						bitIdx <= 4'h0;
						noisePend <= (verifyHighs == 2'h1);
					end
				end
			end
			`RX_FRAME: begin
				if (rtNum == `RT_PER_BIT) begin
					rtNum <= `RT_FIRST;
					bitIdx <= bitIdx + 4'h1;
				end else begin
					rtNum <= rtNum + 5'h01;
				end
				if (rtNum == `RT_VOTE_A) begin
					votes[0] <= serial_in_pin;
				end
				if (rtNum == `RT_VOTE_B) begin
					votes[1] <= serial_in_pin;
				end
				if (rtNum == `RT_VOTE_C) begin
					if (disagree) begin
						noisePend <= 1'b1;
					end
					if (bitIdx == 4'h0) begin
						if (vote) begin
							rxState <= `RX_IDLE;
						end
					end else if (bitIdx != stopIdx) begin
						rxShift <= {vote, rxShift[8:1]};
					end else begin
						// Stop bit: deliver unless asleep and not woken by the top data bit
						if (!rx_sleep || (wakeByAddress && word[8 -
							{3'h0, ~wordLength9}])) begin
							rx_sleep <= 1'b0;
							rxData <= word;
							rx_full_flag <= 1'b1;
							noise_flag <= noisePend | disagree;
							framing_flag <= ~vote;
						end
						if (vote) begin
							rxState <= `RX_IDLE;
						end else if (word == 9'h000) begin
							rxState <= `RX_NEED_HIGH;
						end else begin
							// Stop taken as one, qualifiers forced high
							rxShift[8] <= 1'b1;
							rxState <= `RX_AWAIT;
						end
					end
				end
			end
			`RX_AWAIT: begin
				// Start taken at the stop bit's RT16 tick, one tick before the next bit boundary
				if (rtNum == `RT_PER_BIT) begin
					rtNum <= `RT_FIRST + 5'h01;
					bitIdx <= 4'h0;
					noisePend <= 1'b0;
					rxState <= serial_in_pin ? `RX_IDLE : `RX_FRAME;
				end else begin
					rtNum <= rtNum + 5'h01;
				end
			end
			`RX_NEED_HIGH: begin
				if (highRun >= {3'h0, `RT_PER_BIT}) begin
					rxState <= `RX_IDLE;
				end
			end
			default: rxState <= `RX_IDLE;
			endcase
		end
	end
end

always @(posedge clk) begin
	if (rst) begin
		readData <= 8'h00;
		rxBit8 <= 1'b0;
	end else begin
		readData <= rxData[7:0];
		rxBit8 <= rxData[8];
	end
end

////////////////////////////////////////////////////////////////////////////
// Transmitter with holding FIFO; full FIFO refuses writes via txReady
reg [2:0] txState;
reg [3:0] txCnt;
reg [9:0] txShift;
reg txPop;
reg reArm;
wire fifoValid;
wire [8:0] fifoData;

sync_fifo #(
	.WIDTH(`TX_FIFO_WIDTH),
	.DEPTH(`TX_FIFO_DEPTH),
	.ADDR(`TX_FIFO_ADDR)
) txHolding (
	.clk(clk),
	.rst(rst),
	.inValid(dataWrite),
	.inReady(txReady),
	.inData({txBit8, writeData}),
	.outValid(fifoValid),
	.outReady(txPop),
	.outData(fifoData)
);

always @* begin
	txPop = txTick && (txState == `TX_READY) && txEnable && !reArm
		&& !sendBreak && fifoValid;
end

always @(posedge clk) begin
	if (rst) begin
		txState <= `TX_OFF;
		txCnt <= 4'h0;
		txShift <= 10'h3ff;
		reArm <= 1'b0;
		serialOut <= 1'b1;
		serialOutEn_n <= 1'b1;
		txEmpty <= 1'b1;
		txComplete <= 1'b1;
	end else begin
		txEmpty <= ~fifoValid;
		txComplete <= ~fifoValid && (txState == `TX_READY
			|| txState == `TX_OFF);
		if (!txEnable && txState != `TX_OFF) begin
			reArm <= 1'b1;
		end
		// Pin belongs to the port only while the transmitter is off
		if (txState == `TX_OFF) begin
			serialOutEn_n <= ~port_dir_bit1;
			serialOut <= portOutData;
		end else begin
			serialOutEn_n <= 1'b0;
		end
		if (txState == `TX_OFF && txEnable) begin
			txState <= `TX_PREAMBLE;
			txCnt <= frameLen;
			reArm <= 1'b0;
			serialOut <= 1'b1;
		end else if (txTick) begin
			case (txState)
			`TX_OFF: txState <= `TX_OFF;
			`TX_PREAMBLE: begin
				serialOut <= 1'b1;
				txCnt <= txCnt - 4'h1;
				if (txCnt == 4'h1) begin
					txState <= `TX_READY;
				end
			end
			`TX_READY: begin
				serialOut <= 1'b1;
				if (!txEnable) begin
					txState <= `TX_OFF;
				end else if (reArm) begin
					reArm <= 1'b0;
					txState <= `TX_PREAMBLE;
					txCnt <= frameLen;
				end else if (sendBreak) begin
					serialOut <= 1'b0;
					txCnt <= frameLen - 4'h1;
					txState <= `TX_BREAK;
				end else if (fifoValid) begin
					serialOut <= 1'b0;
					txShift <= {1'b1, wordLength9 ? fifoData[8] : 1'b1,
						fifoData[7:0]};
					txCnt <= frameLen - 4'h1;
					txState <= `TX_DATA;
				end
			end
			`TX_DATA: begin
				serialOut <= txShift[0];
				txShift <= {1'b1, txShift[9:1]};
				txCnt <= txCnt - 4'h1;
				if (txCnt == 4'h1) begin
					txState <= `TX_READY;
				end
			end
			`TX_BREAK: begin
				serialOut <= 1'b0;
				if (txCnt == 4'h1) begin
					if (sendBreak) begin
						txCnt <= frameLen;
					end else begin
						serialOut <= 1'b1;
						txState <= `TX_STOP_HIGH;
					end
				end else begin
					txCnt <= txCnt - 4'h1;
				end
			end
			`TX_STOP_HIGH: begin
				serialOut <= 1'b1;
				txState <= `TX_READY;
			end
			default: txState <= `TX_OFF;
			endcase
		end
	end
end

endmodule

`default_nettype wire

// File: tb/async_serial_props.sv
/*
 Port checker of the serial unit, bound to its top module.
 Assumes one baud setting held while frames are on the line.
*/
`timescale 1ns/1ps
`default_nettype none

module async_serial_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic dataWrite,
	input wire logic txReady,
	input wire logic [4:0] baudSelect,
	input wire logic wakeByAddress,
	input wire logic txEnable,
	input wire logic rx_sleep,
	input wire logic rx_full_flag,
	input wire logic noise_flag,
	input wire logic framing_flag,
	input wire logic txEmpty,
	input wire logic txComplete,
	input wire logic serialOut,
	input wire logic serialOutEn_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [19:0] lowCnt;
	wire [19:0] bitLen = (baudSelect[4:3] == 2'h0 ? 20'h40 :
		baudSelect[4:3] == 2'h1 ? 20'hc0 :
		baudSelect[4:3] == 2'h2 ? 20'h100 : 20'h340) << baudSelect[2:0];

	// Length of the current low run on the driven line
	always_ff @(posedge clk) begin
		if (rst || serialOut || serialOutEn_n)
			lowCnt <= 20'h0;
		else
			lowCnt <= lowCnt + 20'h1;
	end

	sequence txTurnOn;
		$rose(txEnable);
	endsequence
	sequence drivesPin;
		##[1:4] !serialOutEn_n;
	endsequence

	////////////////////////////////////////
	AST_RESET_IDLE: assert property ($fell(rst) |-> serialOut &&
		serialOutEn_n && txEmpty && txComplete && txReady && !rx_full_flag)
		else $error("state after reset wrong");
	AST_PIN_DRIVEN: assert property (txTurnOn |-> drivesPin)
		else $error("pin not driven after enable");
	AST_BIT_MULTIPLE: assert property ($rose(serialOut) && txEnable &&
		!serialOutEn_n |-> lowCnt % bitLen == 20'h0)
		else $error("low run not whole bits");
	AST_LOW_DRIVEN: assert property ($fell(serialOut) && txEnable |->
		!serialOutEn_n)
		else $error("low level on undriven pin");
	AST_FLAGS_WITH_FULL: assert property ($rose(framing_flag) ||
		$rose(noise_flag) |-> rx_full_flag)
		else $error("error flag without full");
	AST_ASLEEP_QUIET: assert property (rx_sleep && !wakeByAddress |=>
		!$rose(rx_full_flag) && !$rose(noise_flag))
		else $error("flag set while asleep");
	AST_WRITE_FILLS: assert property (dataWrite && txReady && txEmpty |->
		##2 !txEmpty)
		else $error("write left buffer empty");
	AST_COMPLETE_EMPTY: assert property (txComplete |-> txEmpty)
		else $error("complete with data pending");
endmodule

bind async_serial_unit async_serial_props chk (.clk(clk), .rst(rst),
	.dataWrite(dataWrite), .txReady(txReady), .baudSelect(baudSelect),
	.wakeByAddress(wakeByAddress), .txEnable(txEnable),
	.rx_sleep(rx_sleep), .rx_full_flag(rx_full_flag),
	.noise_flag(noise_flag), .framing_flag(framing_flag),
	.txEmpty(txEmpty), .txComplete(txComplete), .serialOut(serialOut),
	.serialOutEn_n(serialOutEn_n));
`default_nettype wire

// File: tb/remote_serial_node.sv
/*
 Remote transceiver: sends 8-bit frames, decodes frames it receives.
 Assumes a line that idles high and the bench's bit length in clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module remote_serial_node #(
	parameter int BIT = 64
) (
	input wire logic clk,
	output var logic lineOut,
	input wire logic lineIn
);
	logic [7:0] got[$];
	logic [7:0] word;

	initial lineOut = 1'h1;

	task automatic bitOut(input logic v, input int n);
		lineOut = v;
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Glitch of one sixteenth bit lands on the middle vote only
	task automatic send(input logic [7:0] d, input logic stopBit,
		input int glitch);
		bitOut(1'h0, BIT);
		for (int i = 0; i < 8; i++) begin
			if (i == glitch) begin
				bitOut(d[i], BIT / 2);
				bitOut(!d[i], BIT / 16);
				bitOut(d[i], BIT / 2 - BIT / 16);
			end else
				bitOut(d[i], BIT);
		end
		bitOut(stopBit, BIT);
	endtask

	////////////////////////////////////////
	initial forever begin
		@(negedge lineIn);
		repeat (BIT / 2) @(posedge clk);
		if (lineIn === 1'h0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk);
				word[i] = lineIn;
			end
			repeat (BIT) @(posedge clk);
			got.push_back(word);
		end
	end
endmodule
`default_nettype wire

// File: tb/async_serial_interface_tb_top.sv
/*
 Self-checking bench of the serial unit against a remote transceiver.
 Assumes the fastest baud setting, 64 clocks per bit.
*/
`timescale 1ns/1ps
`default_nettype none

module async_serial_interface_tb_top;
	localparam int BIT = 64;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic dataWrite = 1'h0, dataRead = 1'h0, txEnable = 1'h0;
	logic rxEnable = 1'h0, sendBreak = 1'h0, rxSleepSet = 1'h0;
	logic portDir = 1'h0, wakeByAddress = 1'h0;
	logic [7:0] writeData = 8'h00;
	logic [7:0] readData;
	logic txReady, rx_sleep, rx_full_flag, noise_flag, framing_flag;
	logic txEmpty, txComplete, serialOut, serialOutEn_n, rxLine;
	int fail_count = 0;
	int checks = 0;
	// Released pin sits on its pull-up
	wire logic pinLevel = (serialOutEn_n === 1'h0) ? serialOut : 1'h1;

	async_serial_unit dut (.clk(clk), .rst(rst), .dataWrite(dataWrite),
		.dataRead(dataRead), .writeData(writeData), .txBit8(1'h0),
		.readData(readData), .rxBit8(), .txReady(txReady),
		.baudSelect(5'h00), .wordLength9(1'h0),
		.wakeByAddress(wakeByAddress),
		.txEnable(txEnable), .rxEnable(rxEnable), .sendBreak(sendBreak),
		.rxSleepSet(rxSleepSet), .rx_sleep(rx_sleep),
		.rx_full_flag(rx_full_flag), .noise_flag(noise_flag),
		.framing_flag(framing_flag), .txEmpty(txEmpty),
		.txComplete(txComplete), .serial_in_pin(rxLine),
		.port_dir_bit1(portDir), .portOutData(1'h1),
		.serialOut(serialOut), .serialOutEn_n(serialOutEn_n));
	remote_serial_node #(.BIT(BIT)) peer (.clk(clk), .lineOut(rxLine),
		.lineIn(pinLevel));

	always #4 clk = ~clk;

	////////////////////////////////////////
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] d);
		writeData = d;
		dataWrite = 1'h1;
		cyc(1);
		dataWrite = 1'h0;
		cyc(1);
	endtask

	task automatic waitPeer(input int k);
		for (int n = 0; n < 20000 && peer.got.size() < k; n++)
			cyc(1);
	endtask

	task automatic rxCheck(input logic [7:0] d, input logic nf,
		input logic fe);
		for (int n = 0; n < 2000 && rx_full_flag !== 1'h1; n++)
			cyc(1);
		cyc(2);
		check(readData, d);
		check({rx_full_flag, noise_flag, framing_flag}, {1'h1, nf, fe});
		dataRead = 1'h1;
		cyc(1);
		dataRead = 1'h0;
		cyc(1);
		check(rx_full_flag, 1'h0);
	endtask

	////////////////////////////////////////
	task automatic testTx();
		int n;
		txEnable = 1'h1;
		wr(8'ha5);
		wr(8'h3c);
		check(serialOutEn_n, 1'h0);
		for (n = 4; n < 2000 && pinLevel !== 1'h0; n++)
			cyc(1);
		check(n >= 10 * BIT - 4 && n <= 11 * BIT + 8, 1'h1);
		waitPeer(2);
		check(peer.got[0], 8'ha5);
		check(peer.got[1], 8'h3c);
		cyc(BIT * 2);
		txEnable = 1'h0;
		cyc(BIT + 4);
		check(serialOutEn_n, 1'h1);
		peer.got.delete();
	endtask

	task automatic testFifo();
		for (int i = 0; i < 17; i++)
			wr(8'(i));
		check(txReady, 1'h0);
		txEnable = 1'h1;
		waitPeer(16);
		cyc(BIT * 12);
		check(9'(peer.got.size()), 9'h010);
		check(peer.got[15], 8'h0f);
		sendBreak = 1'h1;
		cyc(BIT * 25);
		sendBreak = 1'h0;
		cyc(BIT * 15);
		check(peer.got[16], 8'h00);
		txEnable = 1'h0;
		cyc(BIT * 2);
		peer.got.delete();
	endtask

	task automatic testFraming();
		fork
			begin
				peer.send(8'h81, 1'h0, -1);
				peer.send(8'h42, 1'h1, -1);
			end
			rxCheck(8'h81, 1'h0, 1'h1);
		join
		rxCheck(8'h42, 1'h0, 1'h0);
	endtask

	task automatic testBreak();
		peer.send(8'h00, 1'h0, -1);
		rxCheck(8'h00, 1'h0, 1'h1);
		peer.bitOut(1'h1, BIT);
		peer.send(8'h24, 1'h1, -1);
		rxCheck(8'h24, 1'h0, 1'h0);
	endtask

	task automatic testSleep();
		fork
			peer.send(8'h11, 1'h1, -1);
			begin
				cyc(200);
				rxSleepSet = 1'h1;
				cyc(1);
				rxSleepSet = 1'h0;
			end
		join
		peer.send(8'h22, 1'h1, -1);
		check({rx_sleep, rx_full_flag}, 2'h2);
		peer.bitOut(1'h1, BIT * 11);
		check(rx_sleep, 1'h0);
		rxSleepSet = 1'h1;
		cyc(1);
		rxSleepSet = 1'h0;
		cyc(2);
		check(rx_sleep, 1'h0);
	endtask

	task automatic testAddrWake();
		wakeByAddress = 1'h1;
		fork
			peer.send(8'h05, 1'h1, -1);
			begin
				cyc(200);
				rxSleepSet = 1'h1;
				cyc(1);
				rxSleepSet = 1'h0;
			end
		join
		check({rx_sleep, rx_full_flag}, 2'h2);
		peer.send(8'h85, 1'h1, -1);
		check(rx_sleep, 1'h0);
		rxCheck(8'h85, 1'h0, 1'h0);
		wakeByAddress = 1'h0;
	endtask

	////////////////////////////////////////
	initial begin
		#400000;
		fail_count++;
		print_verdict();
	end

	initial begin
		cyc(16);
		rst = 1'h0;
		rxEnable = 1'h1;
		cyc(1);
		check({serialOut, serialOutEn_n, txEmpty, txComplete}, 4'hf);
		testTx();
		testFifo();
		peer.send(8'h96, 1'h1, -1);
		rxCheck(8'h96, 1'h0, 1'h0);
		peer.send(8'h5a, 1'h1, 3);
		rxCheck(8'h5a, 1'h1, 1'h0);
		testFraming();
		testBreak();
		testSleep();
		testAddrWake();
		print_verdict();
	end
endmodule
`default_nettype wire
